// File: rtl/acmp_top.sv
// Comparator control logic: AHB-Lite registers, input selection, sync, events.
// Assumes a single AHB-Lite master, one system clock, analogue levels as codes.
//
// Contract
// [R01] Raw result is high exactly when positive input exceeds negative input.
// [R02] Result reaches status bit through a synchroniser, one to two cycles late.
// [R03] With mux enabled and converter off, channel field picks channel 0..7.
// [R04] Mux disabled or converter on: negative input is the negative pin.
// [R05] Bandgap select puts reference on positive input, else positive pin.
// [R06] Power-off bit removes comparator power; writable any time.
// [R07] Flag sets when a synchronised edge matches the selected event type.
// [R08] Flag clears on vector acknowledge or on write of one.
// [R09] Request only when flag, enable and global enable are all set.
// [R10] Capture route bit connects result to capture front end, else none.
// [R11] Event select: 00 toggle, 01 reserved, 10 falling, 11 rising.
// [R12] Software clears enable before changing event select.
// [R13] Software clears enable before changing power-off.
// [R14] Digital-in-off bit forces matching port input read to zero.
// [R15] Software clears converter power reduce before using the mux.
// [R16] Writable bits reset to zero; output bit shows live state.
// [R17] Converter enable means the converter owns its multiplexer.
// [R18] Edge pulses compare synchronised value with previous cycle.
`timescale 1ns/10ps
`default_nettype none
`include "acmp_defs.svh"
module acmp_top (
    input wire logic clk, // System clock 200 MHz
    input wire logic rst, // Async reset, active high
    input wire logic hsel, // AHB slave select
    input wire logic [31:0] haddr, // AHB address
    input wire logic [1:0] htrans, // AHB transfer type
    input wire logic hwrite, // AHB write
    input wire logic [2:0] hsize, // AHB size
    input wire logic [31:0] hwdata, // AHB write data
    input wire logic hready, // AHB bus ready
    output logic [31:0] hrdata, // AHB read data
    output logic hreadyout, // AHB slave ready
    output logic hresp, // AHB response
    input wire logic [9:0] posPinLevel, // Positive pin level
    input wire logic [9:0] negPinLevel, // Negative pin level
    input wire logic [9:0] bandgapLevel, // Bandgap reference level
    input wire logic [79:0] chanLevels, // Converter channel levels
    input wire logic posPinDigital, // Positive pin digital level
    input wire logic negPinDigital, // Negative pin digital level
    input wire logic globalIrqEnable, // Processor global enable
    input wire logic vectorAck, // Processor runs the vector
    output logic irqReq, // Comparator interrupt request
    output logic captureTrigger, // Capture front end source
    output logic captureRouted, // Capture source is comparator
    output logic cmpPowerOff, // Comparator power removed
    output logic [1:0] portInRead, // Port input bits as read
    output logic [1:0] digitalInOff // Input buffer disables
);
    // ----------------------------------------------------------------
    // Registers and bus state
    // ----------------------------------------------------------------
    logic [7:0] csr_q; // Writable control bits
    logic evFlag_q; // Event flag
    logic [7:0] convB_q; // Converter control b
    logic [7:0] didis_q; // Digital input disable
    logic [7:0] convA_q; // Converter control a
    logic [7:0] muxSel_q; // Converter mux select
    logic [7:0] pwr_q; // Power reduce
    logic wrPend_q;
    logic [7:0] wrAddr_q;
    logic cmpRaw;
    logic evMatch;
    logic flagWrClr;
    logic [7:0] rdByte;
    logic [7:0] addrLo;
    acmp_pkg::acmp_evsel_t evSel;
    acmp_evt_if evt ();

    assign addrLo = haddr[7:0];
    assign evSel = acmp_pkg::acmp_evsel_t'(csr_q[`ACMP_BIT_EVSEL_HI:`ACMP_BIT_EVSEL_LO]);

    // ----------------------------------------------------------------
    // Analogue side and synchroniser
    // ----------------------------------------------------------------
    acmp_analog_select u_sel (
        .posPinLevel(posPinLevel),
        .negPinLevel(negPinLevel),
        .bandgapLevel(bandgapLevel),
        .chanLevels(chanLevels),
        .bandgapSelect(csr_q[`ACMP_BIT_BANDGAP]),
        .negMuxEnable(convB_q[`ACMP_BIT_NEGMUX]),
        .converterEnable(convA_q[`ACMP_BIT_CONVEN]),
        .channelSelect(muxSel_q[`ACMP_CHSEL_MSB:0]),
        .powerOff(csr_q[`ACMP_BIT_PWROFF]),
        .cmpRaw(cmpRaw)
    );

    acmp_sync_edge u_sync (
        .clk(clk),
        .rst(rst),
        .cmpRaw(cmpRaw),
        .evt(evt)
    );

    // ----------------------------------------------------------------
    // AHB-Lite slave: address phase capture, zero wait states
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrPend_q <= 1'b0;
            wrAddr_q <= `ACMP_RST_BYTE;
        end else begin
            wrPend_q <= hsel && hready && (htrans == `ACMP_HTRANS_NONSEQ) && hwrite;
            wrAddr_q <= addrLo;
        end
    end

    // Read data mux over register offsets
    always_comb begin
        rdByte = `ACMP_RST_BYTE;
        case (addrLo)
            `ACMP_OFF_CSR: begin
                rdByte = csr_q;
                rdByte[`ACMP_BIT_OUT] = evt.syncOut; // [R02] [R16]
                rdByte[`ACMP_BIT_FLAG] = evFlag_q; // [R07]
            end
            `ACMP_OFF_CONVB: rdByte = convB_q;
            `ACMP_OFF_DIDIS: rdByte = didis_q;
            `ACMP_OFF_CONVA: rdByte = convA_q;
            `ACMP_OFF_MUXSEL: rdByte = muxSel_q;
            `ACMP_OFF_PWR: rdByte = pwr_q;
            default: rdByte = `ACMP_RST_BYTE;
        endcase
    end

    // Read data registered at the address phase, shown in the data phase
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hrdata <= `ACMP_RST_WORD;
        end else if (hsel && hready && (htrans == `ACMP_HTRANS_NONSEQ) && !hwrite) begin
            hrdata <= {24'h000000, rdByte};
        end
    end

    // Always ready, always OKAY
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp <= `ACMP_HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp <= `ACMP_HRESP_OKAY;
        end
    end

    assign flagWrClr = wrPend_q && (wrAddr_q == `ACMP_OFF_CSR) && hwdata[`ACMP_BIT_FLAG];

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    // Plain control bits of the status register; flag and output bit kept apart
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            csr_q <= `ACMP_RST_BYTE; // [R16]
        end else if (wrPend_q && wrAddr_q == `ACMP_OFF_CSR) begin
            csr_q <= {hwdata[`ACMP_BIT_PWROFF:`ACMP_BIT_BANDGAP], 2'h0, hwdata[`ACMP_BIT_IRQEN:`ACMP_BIT_EVSEL_LO]};
        end
    end

    // Other registers written whole
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            convB_q <= `ACMP_RST_BYTE;
            didis_q <= `ACMP_RST_BYTE;
            convA_q <= `ACMP_RST_BYTE;
            muxSel_q <= `ACMP_RST_BYTE;
            pwr_q <= `ACMP_RST_BYTE;
        end else if (wrPend_q) begin
            case (wrAddr_q)
                `ACMP_OFF_CONVB: convB_q <= hwdata[7:0];
                `ACMP_OFF_DIDIS: didis_q <= hwdata[7:0];
                `ACMP_OFF_CONVA: convA_q <= hwdata[7:0];
                `ACMP_OFF_MUXSEL: muxSel_q <= hwdata[7:0];
                `ACMP_OFF_PWR: pwr_q <= hwdata[7:0];
                default: convB_q <= convB_q;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Event flag
    // ----------------------------------------------------------------
    // Event match; reserved code matches nothing
    always_comb begin
        case (evSel)
            acmp_pkg::ACMP_EV_TOGGLE: evMatch = evt.togglePulse; // [R11]
            acmp_pkg::ACMP_EV_FALL: evMatch = evt.fallPulse; // [R11]
            acmp_pkg::ACMP_EV_RISE: evMatch = evt.risePulse; // [R11]
            default: evMatch = 1'b0;
        endcase
    end

    // Set wins over either clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            evFlag_q <= 1'b0; // [R16]
        end else if (evMatch) begin
            evFlag_q <= 1'b1; // [R07]
        end else if (vectorAck || flagWrClr) begin
            evFlag_q <= 1'b0; // [R08]
        end
    end

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irqReq <= 1'b0;
            captureTrigger <= 1'b0;
            captureRouted <= 1'b0;
            cmpPowerOff <= 1'b0;
        end else begin
            irqReq <= evFlag_q && csr_q[`ACMP_BIT_IRQEN] && globalIrqEnable; // [R09]
            captureTrigger <= csr_q[`ACMP_BIT_CAPROUTE] && evt.syncOut; // [R10]
            captureRouted <= csr_q[`ACMP_BIT_CAPROUTE]; // [R10]
            cmpPowerOff <= csr_q[`ACMP_BIT_PWROFF]; // [R06]
        end
    end

    // Input buffer disables and port input reads
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            digitalInOff <= 2'h0;
            portInRead <= 2'h0;
        end else begin
            digitalInOff <= didis_q[`ACMP_BIT_NEGDIS:`ACMP_BIT_POSDIS];
            portInRead[0] <= posPinDigital && !didis_q[`ACMP_BIT_POSDIS]; // [R14]
            portInRead[1] <= negPinDigital && !didis_q[`ACMP_BIT_NEGDIS]; // [R14]
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_edge_match;
        evMatch;
    endsequence
    sequence s_flag_up;
        evFlag_q;
    endsequence

    chk_cmp_pins: assert property (@(posedge clk) disable iff (rst) // [R01] [R04]
        (!csr_q[`ACMP_BIT_PWROFF] && !csr_q[`ACMP_BIT_BANDGAP] && !convB_q[`ACMP_BIT_NEGMUX])
        |-> (cmpRaw == (posPinLevel > negPinLevel)))
        else $error("raw result does not match the pin comparison");

    chk_flag_set: assert property (@(posedge clk) disable iff (rst)
        s_edge_match |=> s_flag_up) // [R07]
        else $error("flag not set after matching edge");
    chk_flag_clear: assert property (@(posedge clk) disable iff (rst)
        (vectorAck && !evMatch) |=> !evFlag_q) // [R08]
        else $error("flag not cleared by vector acknowledge");
    chk_flag_hold: assert property (@(posedge clk) disable iff (rst)
        (evFlag_q && !vectorAck && !flagWrClr) |=> evFlag_q) // [R08]
        else $error("flag dropped without a clear");
    chk_irq_gate: assert property (@(posedge clk) disable iff (rst)
        irqReq |-> $past(evFlag_q && csr_q[`ACMP_BIT_IRQEN] && globalIrqEnable)) // [R09]
        else $error("request without flag, enable and global enable");
    chk_rsvd_quiet: assert property (@(posedge clk) disable iff (rst)
        (evSel == acmp_pkg::ACMP_EV_RSVD) |-> !evMatch) // [R11]
        else $error("reserved event code matched");
    chk_rise_only: assert property (@(posedge clk) disable iff (rst)
        (evSel == acmp_pkg::ACMP_EV_RISE && evMatch) |-> (evt.syncOut && !$past(evt.syncOut))) // [R11]
        else $error("rising mode matched a non-rising edge");
    chk_capture_off: assert property (@(posedge clk) disable iff (rst)
        !$past(csr_q[`ACMP_BIT_CAPROUTE]) |-> !captureTrigger) // [R10]
        else $error("capture trigger while route is off");
    chk_port_masked: assert property (@(posedge clk) disable iff (rst)
        $past(didis_q[`ACMP_BIT_POSDIS]) |-> !portInRead[0]) // [R14]
        else $error("disabled pin read as one");
endmodule
`default_nettype wire

// File: include/acmp_defs.svh
// Constants for the comparator control block: offsets, bit positions, reset values.
// Assumes inclusion by bare name from every file that needs them.
`ifndef ACMP_DEFS_SVH
`define ACMP_DEFS_SVH

`define ACMP_OFF_CSR 8'h30
`define ACMP_OFF_CONVB 8'h34
`define ACMP_OFF_DIDIS 8'h38
`define ACMP_OFF_CONVA 8'h3C
`define ACMP_OFF_MUXSEL 8'h40
`define ACMP_OFF_PWR 8'h44

`define ACMP_BIT_EVSEL_LO 0
`define ACMP_BIT_EVSEL_HI 1
`define ACMP_BIT_CAPROUTE 2
`define ACMP_BIT_IRQEN 3
`define ACMP_BIT_FLAG 4
`define ACMP_BIT_OUT 5
`define ACMP_BIT_BANDGAP 6
`define ACMP_BIT_PWROFF 7
`define ACMP_BIT_NEGMUX 6
`define ACMP_BIT_CONVEN 7
`define ACMP_BIT_POSDIS 0
`define ACMP_BIT_NEGDIS 1
`define ACMP_BIT_PWRRED 0
`define ACMP_CHSEL_MSB 2

`define ACMP_RST_BYTE 8'h00
`define ACMP_RST_WORD 32'h0000_0000
`define ACMP_HTRANS_NONSEQ 2'h2
`define ACMP_HRESP_OKAY 1'h0

`endif

// File: include/acmp_pkg.sv
// Types for the comparator control block.
// Assumes nothing beyond a SystemVerilog compiler.
package acmp_pkg;
    // Event kinds chosen by the event select field
    typedef enum logic [1:0] {
        ACMP_EV_TOGGLE = 2'h0,
        ACMP_EV_RSVD = 2'h1,
        ACMP_EV_FALL = 2'h2,
        ACMP_EV_RISE = 2'h3
    } acmp_evsel_t;
    // Edge detector watch state
    typedef enum logic [1:0] {
        ACMP_ST_IDLE = 2'h0,
        ACMP_ST_ARMED = 2'h1,
        ACMP_ST_RSVD = 2'h2
    } acmp_state_t;
endpackage

// File: include/acmp_evt_if.sv
// Interface carrying the synchronised comparator result and its edge pulses.
// Assumes one clock shared by both ends.
`timescale 1ns/10ps
`default_nettype none
interface acmp_evt_if;
    logic syncOut;
    logic risePulse;
    logic fallPulse;
    logic togglePulse;
    modport src (output syncOut, output risePulse, output fallPulse, output togglePulse);
    modport dst (input syncOut, input risePulse, input fallPulse, input togglePulse);
endinterface
`default_nettype wire

// File: rtl/acmp_sync_edge.sv
// Synchroniser and edge detector for the raw comparator result.
// Assumes cmpRaw is asynchronous to clk.
`timescale 1ns/10ps
`default_nettype none
`include "acmp_defs.svh"
module acmp_sync_edge (
    input wire logic clk, // System clock
    input wire logic rst, // Async reset, active high
    input wire logic cmpRaw, // Raw comparator result
    acmp_evt_if.src evt // Synchronised result and pulses
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    // Two-stage synchroniser; first stage feeds only the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= cmpRaw;
            sync_q <= meta_q; // [R02]
        end
    end

    // Previous synchronised value for edge compare
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= sync_q;
        end
    end

    // Single-cycle edge pulses
    assign evt.syncOut = sync_q;
    assign evt.risePulse = sync_q & ~prev_q; // [R18]
    assign evt.fallPulse = ~sync_q & prev_q; // [R18]
    assign evt.togglePulse = sync_q ^ prev_q; // [R18]

    chk_sync_latency: assert property (@(posedge clk) disable iff (rst)
        !$past(rst, 2) |-> (sync_q == $past(cmpRaw, 2))) // [R02]
        else $error("synchronised output does not follow raw result after two edges");
    chk_toggle_pulse: assert property (@(posedge clk) disable iff (rst)
        (evt.risePulse == (sync_q && !$past(sync_q))) && (evt.togglePulse == (sync_q != $past(sync_q)))) // [R18]
        else $error("edge pulse does not match the synchronised change");
endmodule
`default_nettype wire

// File: rtl/acmp_analog_select.sv
// Input selection model and comparator decision for the analogue core.
// Assumes input voltages arrive as unsigned codes of equal scale.
`timescale 1ns/10ps
`default_nettype none
`include "acmp_defs.svh"
module acmp_analog_select (
    input wire logic [9:0] posPinLevel, // Positive pin level
    input wire logic [9:0] negPinLevel, // Negative pin level
    input wire logic [9:0] bandgapLevel, // Bandgap reference level
    input wire logic [79:0] chanLevels, // Converter channels 0..7
    input wire logic bandgapSelect, // Bandgap onto positive input
    input wire logic negMuxEnable, // Multiplexer onto negative input
    input wire logic converterEnable, // Converter owns multiplexer
    input wire logic [2:0] channelSelect, // Channel index
    input wire logic powerOff, // Comparator unpowered
    output logic cmpRaw // Raw comparison result
);
    logic [9:0] posLevel;
    logic [9:0] negLevel;
    logic [9:0] chanLevel;

    // Channel picked by index
    assign chanLevel = chanLevels[channelSelect*10 +: 10]; // [R03]
    // Positive input choice
    assign posLevel = bandgapSelect ? bandgapLevel : posPinLevel; // [R05]
    // Negative input choice; converter enable returns it to the pin
    assign negLevel = (negMuxEnable && !converterEnable) ? chanLevel : negPinLevel; // [R04] [R17]
    // Compare; unpowered comparator outputs low
    assign cmpRaw = !powerOff && (posLevel > negLevel); // [R01] [R06]
endmodule
`default_nettype wire

// File: bench/acmp_far_model.sv
// Analogue side of the comparator: pin, bandgap and channel levels, pin digital levels.
// Assumes the bench calls its tasks; every change lands by NBA after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module acmp_far_model (
    input wire logic clk, // System clock
    output logic [9:0] posPinLevel, // Positive pin level
    output logic [9:0] negPinLevel, // Negative pin level
    output logic [9:0] bandgapLevel, // Bandgap level
    output logic [79:0] chanLevels, // Channel levels
    output logic posPinDigital, // Positive pin digital level
    output logic negPinDigital // Negative pin digital level
);
    // Quiet start: all levels low
    initial begin
        posPinLevel = 10'h000;
        negPinLevel = 10'h000;
        bandgapLevel = 10'h000;
        chanLevels = 80'h0;
        posPinDigital = 1'b0;
        negPinDigital = 1'b0;
    end
    // Pin and reference levels
    task automatic set_levels(input logic [9:0] p, input logic [9:0] n, input logic [9:0] b);
        @(posedge clk);
        posPinLevel <= p;
        negPinLevel <= n;
        bandgapLevel <= b;
    endtask
    // Channel k low, every other channel at full scale
    task automatic set_chan(input int k);
        logic [79:0] v;
        v = {8{10'h3FF}};
        v[10*k +: 10] = 10'h000;
        @(posedge clk);
        chanLevels <= v;
    endtask
    // Digital level seen on the two pins
    task automatic set_digital(input logic p, input logic n);
        @(posedge clk);
        posPinDigital <= p;
        negPinDigital <= n;
    endtask
endmodule
`default_nettype wire

// File: bench/acmp_top_tb_top.sv
// Self-checking bench for the comparator control block.
// Assumes zero-wait AHB-Lite slave and the analogue model in acmp_far_model.
`timescale 1ns/10ps
`default_nettype none
`include "acmp_defs.svh"
module acmp_top_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0, hwrite = 1'b0, globalIrqEnable = 1'b0, vectorAck = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
    logic [1:0] htrans = 2'h0, portInRead, digitalInOff;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, irqReq, captureTrigger, captureRouted, cmpPowerOff;
    logic [9:0] posL, negL, bgL;
    logic [79:0] chL;
    logic posD, negD;
    int fails = 0, num_checks = 0, cycles = 0;
    logic [7:0] offs [6] = '{`ACMP_OFF_CSR, `ACMP_OFF_CONVB, `ACMP_OFF_DIDIS,
                             `ACMP_OFF_CONVA, `ACMP_OFF_MUXSEL, `ACMP_OFF_PWR};
    // ----------------------------------------
    // Clock, instances, timeout
    // ----------------------------------------
    always #2.5 clk = ~clk;
    acmp_top i_acmp_top (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .posPinLevel(posL), .negPinLevel(negL),
        .bandgapLevel(bgL), .chanLevels(chL), .posPinDigital(posD), .negPinDigital(negD),
        .globalIrqEnable(globalIrqEnable), .vectorAck(vectorAck), .irqReq(irqReq),
        .captureTrigger(captureTrigger), .captureRouted(captureRouted),
        .cmpPowerOff(cmpPowerOff), .portInRead(portInRead), .digitalInOff(digitalInOff));
    acmp_far_model i_acmp_far_model (.clk(clk), .posPinLevel(posL), .negPinLevel(negL),
        .bandgapLevel(bgL), .chanLevels(chL), .posPinDigital(posD), .negPinDigital(negD));
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            $display("FAIL %0t run did not complete", $time);
            end_sim();
        end
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    // Verdict and end of run
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // One single AHB-Lite transfer, waits on hready in both phases
    task automatic xfer(input logic wr, input logic [7:0] off, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= `ACMP_HTRANS_NONSEQ;
        haddr <= {24'h0, off};
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
        check(32'(hresp), 32'(`ACMP_HRESP_OKAY), "response code");
    endtask
    task automatic wr(input logic [7:0] off, input logic [31:0] d);
        xfer(1'b1, off, d);
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // Read a register and compare the bits under mask
    task automatic chk_reg(input logic [7:0] off, input logic [31:0] m, input logic [31:0] e, input string w);
        xfer(1'b0, off, 32'h0);
        check(r & m, e, w);
    endtask
    // Let the synchroniser settle, then read one status bit
    task automatic chk_bit(input int b, input logic e, input string w);
        repeat (5) @(posedge clk);
        chk_reg(`ACMP_OFF_CSR, 32'h1 << b, 32'(e) << b, w);
    endtask
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        foreach (offs[i]) chk_reg(offs[i], 32'hFFFF_FFDF, 32'h0, "reset value");
        wr(8'h80, 32'h0000_00FF);
        chk_reg(8'h80, 32'hFFFF_FFFF, 32'h0, "unmapped read");
        // Comparison and positive input choice
        i_acmp_far_model.set_levels(10'h200, 10'h100, 10'h050);
        chk_bit(5, 1'b1, "pos above neg");
        i_acmp_far_model.set_levels(10'h100, 10'h200, 10'h300);
        chk_bit(5, 1'b0, "pos below neg");
        i_acmp_far_model.set_levels(10'h200, 10'h200, 10'h300);
        chk_bit(5, 1'b0, "pos equal neg");
        i_acmp_far_model.set_levels(10'h100, 10'h200, 10'h300);
        wr(`ACMP_OFF_CSR, 32'h40);
        chk_bit(5, 1'b1, "bandgap on pos");
        wr(`ACMP_OFF_CSR, 32'h00);
        chk_bit(5, 1'b0, "pin on pos");
        // Converter channels onto the negative input
        wr(`ACMP_OFF_PWR, 32'h0);
        wr(`ACMP_OFF_CONVA, 32'h0);
        wr(`ACMP_OFF_CONVB, 32'h40);
        i_acmp_far_model.set_levels(10'h200, 10'h3FF, 10'h000);
        for (int k = 0; k < 8; k++) begin
            i_acmp_far_model.set_chan(k);
            wr(`ACMP_OFF_MUXSEL, 32'(k));
            chk_bit(5, 1'b1, "selected channel");
            wr(`ACMP_OFF_MUXSEL, 32'((k + 1) % 8));
            chk_bit(5, 1'b0, "other channel");
        end
        wr(`ACMP_OFF_MUXSEL, 32'h7);
        wr(`ACMP_OFF_CONVA, 32'h80);
        chk_bit(5, 1'b0, "converter owns mux");
        wr(`ACMP_OFF_CONVA, 32'h0);
        wr(`ACMP_OFF_CONVB, 32'h0);
        chk_bit(5, 1'b0, "mux disabled");
        // Event modes, enable kept clear while the mode changes
        i_acmp_far_model.set_levels(10'h100, 10'h200, 10'h000);
        for (int m = 0; m < 4; m++) begin
            wr(`ACMP_OFF_CSR, 32'(m));
            wr(`ACMP_OFF_CSR, 32'(m) | 32'h10);
            i_acmp_far_model.set_levels(10'h200, 10'h100, 10'h000);
            chk_bit(4, m == 0 || m == 3, "flag on rise");
            wr(`ACMP_OFF_CSR, 32'(m));
            chk_bit(4, m == 0 || m == 3, "write zero keeps flag");
            wr(`ACMP_OFF_CSR, 32'(m) | 32'h10);
            chk_bit(4, 1'b0, "write one clears flag");
            i_acmp_far_model.set_levels(10'h100, 10'h200, 10'h000);
            chk_bit(4, m == 0 || m == 2, "flag on fall");
            wr(`ACMP_OFF_CSR, 32'(m) | 32'h10);
        end
        // Request gating and vector acknowledge
        wr(`ACMP_OFF_CSR, 32'h0B);
        globalIrqEnable <= 1'b1;
        i_acmp_far_model.set_levels(10'h200, 10'h100, 10'h000);
        repeat (6) @(posedge clk);
        check(32'(irqReq), 32'h1, "request raised");
        globalIrqEnable <= 1'b0;
        repeat (3) @(posedge clk);
        check(32'(irqReq), 32'h0, "global enable off");
        globalIrqEnable <= 1'b1;
        wr(`ACMP_OFF_CSR, 32'h03);
        repeat (3) @(posedge clk);
        check(32'(irqReq), 32'h0, "local enable off");
        wr(`ACMP_OFF_CSR, 32'h0B);
        repeat (3) @(posedge clk);
        check(32'(irqReq), 32'h1, "request back");
        vectorAck <= 1'b1;
        @(posedge clk);
        vectorAck <= 1'b0;
        repeat (3) @(posedge clk);
        check(32'(irqReq), 32'h0, "request after vector");
        chk_bit(4, 1'b0, "flag after vector");
        // Capture routing, result currently high
        wr(`ACMP_OFF_CSR, 32'h03);
        wr(`ACMP_OFF_CSR, 32'h04);
        repeat (5) @(posedge clk);
        check(32'({captureRouted, captureTrigger}), 32'h3, "routed high");
        i_acmp_far_model.set_levels(10'h100, 10'h200, 10'h000);
        repeat (5) @(posedge clk);
        check(32'(captureTrigger), 32'h0, "routed low");
        i_acmp_far_model.set_levels(10'h200, 10'h100, 10'h000);
        wr(`ACMP_OFF_CSR, 32'h00);
        repeat (5) @(posedge clk);
        check(32'({captureRouted, captureTrigger}), 32'h0, "not routed");
        // Power off with enable clear
        wr(`ACMP_OFF_CSR, 32'h80);
        repeat (5) @(posedge clk);
        chk_reg(`ACMP_OFF_CSR, 32'hA0, 32'h80, "powered off reads");
        check(32'(cmpPowerOff), 32'h1, "power off output");
        wr(`ACMP_OFF_CSR, 32'h00);
        chk_bit(5, 1'b1, "powered again");
        // Digital input buffers
        i_acmp_far_model.set_digital(1'b1, 1'b1);
        for (int d = 0; d < 4; d++) begin
            wr(`ACMP_OFF_DIDIS, 32'(d));
            repeat (3) @(posedge clk);
            check(32'({digitalInOff, portInRead}), 32'((d << 2) | (~d & 3)), "input disable");
        end
        end_sim();
    end
endmodule
`default_nettype wire
